//--- core/residual_diff_stage.sv
// residual differential stage: phasor math, status, events, records
`timescale 1ns/1ps
`include "resdiff_params.svh"
// Function
// - differential: phase sum plus or minus residual
// - bias: average of two or maximum of four
// - threshold: pick-up plus two slope terms
// - blocking input sampled at cycle start
// - pick-up unblocked raises trip
// - pick-up blocked raises blocked only
// - blocking clears an active trip
// - condition reads normal, trip or blocked
// - four events: trip and block, on, off
// - mask per event picks stored edges
// - clearable trip and block counters
// - on-events write twelve newest records
// - record holds time, event, currents, group
// - compensation while energized zeroes calculated residual, cable mode
// - forcing overrides status
module residual_diff_stage
  import resdiff_pkg::*;
(
  input  wire logic                  sys_clk,          // 200 MHz clock
  input  wire logic                  resetn,           // async reset
  input  wire logic                  cycle_start,      // program cycle pulse
  input  wire logic [`PH_W-1:0]      phase_a_re,       // phase a real
  input  wire logic [`PH_W-1:0]      phase_a_im,       // phase a imag
  input  wire logic [`PH_W-1:0]      phase_b_re,       // phase b real
  input  wire logic [`PH_W-1:0]      phase_b_im,       // phase b imag
  input  wire logic [`PH_W-1:0]      phase_c_re,       // phase c real
  input  wire logic [`PH_W-1:0]      phase_c_im,       // phase c imag
  input  wire logic [`PH_W-1:0]      res_one_re,       // residual one real
  input  wire logic [`PH_W-1:0]      res_one_im,       // residual one imag
  input  wire logic [`PH_W-1:0]      res_two_re,       // residual two real
  input  wire logic [`PH_W-1:0]      res_two_im,       // residual two imag
  input  wire logic                  block_in,         // blocking matrix
  input  wire logic                  residual_sel,     // 1: input two
  input  wire logic                  direction_sub,    // 1: subtract
  input  wire logic                  bias_max_mode,    // 1: maximum mode
  input  wire logic                  cable_end_diff_mode, // offset in use
  input  wire logic                  comp_cmd,         // compensate pulse
  input  wire logic                  energized,        // line energized
  input  wire logic [`CUR_W-1:0]     pickup_set,       // basic pick-up
  input  wire logic [`CUR_W-1:0]     first_turnpoint,  // knee one
  input  wire logic [`SLOPE_W-1:0]   first_slope,      // slope one
  input  wire logic [`CUR_W-1:0]     second_turnpoint, // knee two
  input  wire logic [`SLOPE_W-1:0]   second_slope,     // slope two
  input  wire logic                  force_enable,     // forcing allowed
  input  wire logic [1:0]            force_status,     // forced condition
  input  wire logic [3:0]            event_mask,       // store enables
  input  wire logic                  clr_trip_count,   // clear trip count
  input  wire logic                  clr_block_count,  // clear block count
  input  wire logic [`TS_W-1:0]      time_stamp,       // ms time of day
  input  wire logic [`GRP_W-1:0]     setting_group,    // active group
  input  wire logic [`REC_IDX_W-1:0] rec_rd_idx,       // record select
  output logic      [1:0]            condition,        // stage status
  output logic                       trip_out,         // trip level
  output logic                       blocked_out,      // blocked level
  output logic                       pickup_out,       // pick-up level
  output logic      [3:0]            event_store,      // event pulses
  output logic      [`TS_W-1:0]      event_time,       // event time
  output logic      [`CNT_W-1:0]     trip_count,       // trip events
  output logic      [`CNT_W-1:0]     block_count,      // blocked events
  output logic      [`REC_W-1:0]     rec_rd_data,      // record read
  output logic      [`REC_IDX_W-1:0] rec_count         // records held
);
  typedef logic signed [`CUR_W-1:0] sc_t;

  function automatic cur_t absv(input sc_t v);
    absv = v[`CUR_W-1] ? cur_t'(-v) : cur_t'(v);
  endfunction

  // max plus half min magnitude estimate
  function automatic cur_t mag(input sc_t re, input sc_t im);
    cur_t a;
    cur_t b;
    logic [`CUR_W:0] s;
    a = absv(re);
    b = absv(im);
    s = (a > b) ? {1'b0, a} + {2'b00, b[`CUR_W-1:1]}
                : {1'b0, b} + {2'b00, a[`CUR_W-1:1]};
    mag = s[`CUR_W] ? `CUR_MAX : s[`CUR_W-1:0];
  endfunction

  function automatic cur_t max2(input cur_t a, input cur_t b);
    max2 = (a > b) ? a : b;
  endfunction

  function automatic sc_t sx(input logic [`PH_W-1:0] v);
    sx = sc_t'(signed'(v));
  endfunction

  sc_t  sum_re, sum_im, calc_re, calc_im, meas_re, meas_im;
  sc_t  diff_re, diff_im;
  sc_t  off_re_reg, off_im_reg;
  cur_t calc_mag, meas_mag, bias_now;
  logic [`CUR_W:0] avg_sum;

  always_comb begin
    sum_re  = sx(phase_a_re) + sx(phase_b_re) + sx(phase_c_re);
    sum_im  = sx(phase_a_im) + sx(phase_b_im) + sx(phase_c_im);
    calc_re = cable_end_diff_mode ? sum_re - off_re_reg : sum_re;
    calc_im = cable_end_diff_mode ? sum_im - off_im_reg : sum_im;
    meas_re = residual_sel ? sx(res_two_re) : sx(res_one_re);
    meas_im = residual_sel ? sx(res_two_im) : sx(res_one_im);
    diff_re = direction_sub ? calc_re - meas_re : calc_re + meas_re;
    diff_im = direction_sub ? calc_im - meas_im : calc_im + meas_im;
    calc_mag = mag(calc_re, calc_im);
    meas_mag = mag(meas_re, meas_im);
    avg_sum  = {1'b0, calc_mag} + {1'b0, meas_mag};
    if (bias_max_mode) begin
      bias_now = max2(max2(mag(sx(phase_a_re), sx(phase_a_im)),
                           mag(sx(phase_b_re), sx(phase_b_im))),
                      max2(mag(sx(phase_c_re), sx(phase_c_im)),
                           meas_mag));
    end else begin
      bias_now = avg_sum[`CUR_W:1];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      off_re_reg <= '0;
      off_im_reg <= '0;
    end else if (comp_cmd && energized) begin
      off_re_reg <= sum_re;
      off_im_reg <= sum_im;
    end
  end

  // stage one: magnitudes and sampled blocking
  logic s1_valid_reg, blk1_reg;
  cur_t bias1_reg, diff1_reg, calc1_reg, meas1_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_valid_reg <= 1'b0;
      blk1_reg     <= 1'b0;
      bias1_reg    <= `CUR_ZERO;
      diff1_reg    <= `CUR_ZERO;
      calc1_reg    <= `CUR_ZERO;
      meas1_reg    <= `CUR_ZERO;
    end else begin
      s1_valid_reg <= cycle_start;
      if (cycle_start) begin
        blk1_reg  <= block_in;
        bias1_reg <= bias_now;
        diff1_reg <= mag(diff_re, diff_im);
        calc1_reg <= calc_mag;
        meas1_reg <= meas_mag;
      end
    end
  end

  cur_t thr_reg;
  diff_charact u_charact (
    .sys_clk          (sys_clk),
    .resetn           (resetn),
    .load             (s1_valid_reg),
    .bias             (bias1_reg),
    .pickup_set       (pickup_set),
    .first_turnpoint  (first_turnpoint),
    .first_slope      (first_slope),
    .second_turnpoint (second_turnpoint),
    .second_slope     (second_slope),
    .thr_reg          (thr_reg)
  );

  // stage two: aligned with the threshold
  logic s2_valid_reg, blk2_reg;
  cur_t bias2_reg, diff2_reg, calc2_reg, meas2_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s2_valid_reg <= 1'b0;
      blk2_reg     <= 1'b0;
      bias2_reg    <= `CUR_ZERO;
      diff2_reg    <= `CUR_ZERO;
      calc2_reg    <= `CUR_ZERO;
      meas2_reg    <= `CUR_ZERO;
    end else begin
      s2_valid_reg <= s1_valid_reg;
      if (s1_valid_reg) begin
        blk2_reg  <= blk1_reg;
        bias2_reg <= bias1_reg;
        diff2_reg <= diff1_reg;
        calc2_reg <= calc1_reg;
        meas2_reg <= meas1_reg;
      end
    end
  end

  // stage three: condition, events, counters, records
  logic       pickup_now;
  logic [1:0] cond_next;
  logic [3:0] ev_raw;
  assign pickup_now = diff2_reg > thr_reg;

  always_comb begin
    cond_next = condition;
    if (s2_valid_reg) begin
      if (!pickup_now) begin
        cond_next = `COND_NORMAL;
      end else if (blk2_reg) begin
        cond_next = `COND_BLOCK;
      end else begin
        cond_next = `COND_TRIP;
      end
    end
    if (force_enable) begin
      cond_next = force_status;
    end
    ev_raw[0] = (cond_next == `COND_TRIP) && (condition != `COND_TRIP);
    ev_raw[1] = (cond_next != `COND_TRIP) && (condition == `COND_TRIP);
    ev_raw[2] = (cond_next == `COND_BLOCK) && (condition != `COND_BLOCK);
    ev_raw[3] = (cond_next != `COND_BLOCK) && (condition == `COND_BLOCK);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      condition   <= `COND_NORMAL;
      trip_out    <= 1'b0;
      blocked_out <= 1'b0;
      pickup_out  <= 1'b0;
    end else begin
      condition   <= cond_next;
      trip_out    <= cond_next == `COND_TRIP;
      blocked_out <= cond_next == `COND_BLOCK;
      if (s2_valid_reg) begin
        pickup_out <= pickup_now;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      event_store <= 4'h0;
      event_time  <= '0;
    end else begin
      event_store <= ev_raw & event_mask;
      if (|ev_raw) begin
        event_time <= time_stamp;
      end
    end
  end

  // an increment in the clearing cycle still counts
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      trip_count <= '0;
    end else if (ev_raw[0]) begin
      trip_count <= clr_trip_count ? `CNT_ONE : trip_count + `CNT_ONE;
    end else if (clr_trip_count) begin
      trip_count <= '0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      block_count <= '0;
    end else if (ev_raw[2]) begin
      block_count <= clr_block_count ? `CNT_ONE
                                     : block_count + `CNT_ONE;
    end else if (clr_block_count) begin
      block_count <= '0;
    end
  end

  // maxima held while the stage is out of normal
  cur_t bmax_reg, dmax_reg, tmax_reg, bmax_n, dmax_n, tmax_n;
  always_comb begin
    if (condition == `COND_NORMAL) begin
      bmax_n = bias2_reg;
      dmax_n = diff2_reg;
      tmax_n = thr_reg;
    end else begin
      bmax_n = max2(bmax_reg, bias2_reg);
      dmax_n = max2(dmax_reg, diff2_reg);
      tmax_n = max2(tmax_reg, thr_reg);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bmax_reg <= `CUR_ZERO;
      dmax_reg <= `CUR_ZERO;
      tmax_reg <= `CUR_ZERO;
    end else if (s2_valid_reg) begin
      bmax_reg <= bmax_n;
      dmax_reg <= dmax_n;
      tmax_reg <= tmax_n;
    end
  end

  logic [`REC_W-1:0] rec_data;
  assign rec_data = {time_stamp, ev_raw[0] ? `EV_TRIP_ON : `EV_BLK_ON,
                     setting_group, bias2_reg, diff2_reg, thr_reg,
                     bmax_n, dmax_n, tmax_n, calc2_reg, meas2_reg};

  rec_mem u_rec (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .wr_en       (ev_raw[0] | ev_raw[2]),
    .wr_data     (rec_data),
    .rd_idx      (rec_rd_idx),
    .rd_data_reg (rec_rd_data),
    .count_reg   (rec_count)
  );

  property p_blk_sample;
    @(posedge sys_clk) disable iff (!resetn)
    cycle_start |-> ##2 blk2_reg == $past(block_in, 2);
  endproperty
  a_blk_sample: assert property (p_blk_sample)
    else $error("blocking not sampled at cycle start");

  property p_trip;
    @(posedge sys_clk) disable iff (!resetn)
    s2_valid_reg && !force_enable && pickup_now && !blk2_reg
      |=> trip_out && !blocked_out && condition == `COND_TRIP;
  endproperty
  a_trip: assert property (p_trip)
    else $error("unblocked pick-up did not trip");

  property p_blocked;
    @(posedge sys_clk) disable iff (!resetn)
    s2_valid_reg && !force_enable && pickup_now && blk2_reg
      |=> blocked_out && !trip_out;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("blocked pick-up handled wrongly");

  property p_release;
    @(posedge sys_clk) disable iff (!resetn)
    s2_valid_reg && !force_enable && !pickup_now
      |=> condition == `COND_NORMAL && !trip_out;
  endproperty
  a_release: assert property (p_release)
    else $error("stage did not release");

  property p_thr_flat;
    @(posedge sys_clk) disable iff (!resetn)
    s1_valid_reg && bias1_reg <= first_turnpoint && $stable(pickup_set)
      |=> thr_reg == pickup_set;
  endproperty
  a_thr_flat: assert property (p_thr_flat)
    else $error("threshold below knee is not pick-up");

  property p_event_on;
    @(posedge sys_clk) disable iff (!resetn)
    $rose(trip_out) |-> event_store[0] == $past(event_mask[0]);
  endproperty
  a_event_on: assert property (p_event_on)
    else $error("trip on event not stored per mask");

  property p_count;
    @(posedge sys_clk) disable iff (!resetn)
    $rose(blocked_out) && !$past(clr_block_count)
      |-> block_count == $past(block_count) + `CNT_ONE;
  endproperty
  a_count: assert property (p_count)
    else $error("block count did not step");

  property p_force;
    @(posedge sys_clk) disable iff (!resetn)
    force_enable |=> condition == $past(force_status);
  endproperty
  a_force: assert property (p_force)
    else $error("forced status not applied");

  property p_rec;
    @(posedge sys_clk) disable iff (!resetn)
    ev_raw[0] && rec_count < `REC_IDX_W'(`REC_DEPTH)
      |=> rec_count == $past(rec_count) + `REC_ONE;
  endproperty
  a_rec: assert property (p_rec)
    else $error("record not written on trip");

  c_trip:    cover property (@(posedge sys_clk) $rose(trip_out));
  c_blocked: cover property (@(posedge sys_clk) $rose(blocked_out));
  c_trip_to_blk: cover property (@(posedge sys_clk)
    trip_out ##1 blocked_out);
  c_rec_full: cover property (@(posedge sys_clk)
    rec_count == `REC_IDX_W'(`REC_DEPTH) && ev_raw[0]);
endmodule

//--- include/resdiff_params.svh
// constants of the residual differential stage
`ifndef RESDIFF_PARAMS_SVH
`define RESDIFF_PARAMS_SVH
`define PH_W        16
`define CUR_W       20
`define SLOPE_W     16
`define SLOPE_DEN   36'd10000
`define TS_W        48
`define GRP_W       3
`define CNT_W       16
`define REC_DEPTH   12
`define REC_IDX_W   4
`define REC_W       213
`define COND_NORMAL 2'h0
`define COND_TRIP   2'h1
`define COND_BLOCK  2'h2
`define EV_TRIP_ON  2'h0
`define EV_TRIP_OFF 2'h1
`define EV_BLK_ON   2'h2
`define EV_BLK_OFF  2'h3
`define CUR_MAX     20'hFFFFF
`define CUR_ZERO    20'h00000
`define CNT_ONE     16'h0001
`define REC_ONE     4'h1
`endif

//--- include/resdiff_pkg.sv
// types of the residual differential stage
package resdiff_pkg;
  typedef enum logic [1:0] {
    COND_NORMAL_E  = 2'b00,
    COND_TRIP_E    = 2'b01,
    COND_BLOCKED_E = 2'b10
  } cond_t;
  typedef logic [19:0] cur_t;
endpackage

//--- core/diff_charact.sv
// two-slope operate threshold, registered
`timescale 1ns/1ps
`include "resdiff_params.svh"
module diff_charact
  import resdiff_pkg::*;
(
  input  wire logic                  sys_clk,          // clock
  input  wire logic                  resetn,           // async reset
  input  wire logic                  load,             // take new bias
  input  wire logic [`CUR_W-1:0]     bias,             // bias current
  input  wire logic [`CUR_W-1:0]     pickup_set,       // basic pick-up
  input  wire logic [`CUR_W-1:0]     first_turnpoint,  // knee one
  input  wire logic [`SLOPE_W-1:0]   first_slope,      // 0.01 % units
  input  wire logic [`CUR_W-1:0]     second_turnpoint, // knee two
  input  wire logic [`SLOPE_W-1:0]   second_slope,     // 0.01 % units
  output logic      [`CUR_W-1:0]     thr_reg           // operate threshold
);
  function automatic logic [`CUR_W-1:0] slope_term(
    input logic [`CUR_W-1:0]   excess,
    input logic [`SLOPE_W-1:0] slope);
    logic [35:0] prod;
    prod = excess * slope;
    prod = prod / `SLOPE_DEN;
    slope_term = (prod > {16'h0000, `CUR_MAX}) ? `CUR_MAX
                                               : prod[`CUR_W-1:0];
  endfunction

  logic [`CUR_W-1:0] ex1;
  logic [`CUR_W-1:0] ex2;
  logic [`CUR_W+1:0] sum;
  logic [`CUR_W-1:0] thr_next;

  always_comb begin
    ex1 = `CUR_ZERO;
    ex2 = `CUR_ZERO;
    if (bias > second_turnpoint) begin
      ex1 = second_turnpoint - first_turnpoint;
      ex2 = bias - second_turnpoint;
    end else if (bias > first_turnpoint) begin
      ex1 = bias - first_turnpoint;
    end
    sum = {2'b00, pickup_set} + {2'b00, slope_term(ex1, first_slope)}
        + {2'b00, slope_term(ex2, second_slope)};
    thr_next = (sum > {2'b00, `CUR_MAX}) ? `CUR_MAX : sum[`CUR_W-1:0];
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      thr_reg <= `CUR_ZERO;
    end else if (load) begin
      thr_reg <= thr_next;
    end
  end
endmodule

//--- core/rec_mem.sv
// twelve-entry ring of trip and block records
`timescale 1ns/1ps
`include "resdiff_params.svh"
module rec_mem
  import resdiff_pkg::*;
(
  input  wire logic                  sys_clk,     // clock
  input  wire logic                  resetn,      // async reset
  input  wire logic                  wr_en,       // store one record
  input  wire logic [`REC_W-1:0]     wr_data,     // record contents
  input  wire logic [`REC_IDX_W-1:0] rd_idx,      // 0 is the newest
  output logic      [`REC_W-1:0]     rd_data_reg, // registered read
  output logic      [`REC_IDX_W-1:0] count_reg    // records held
);
  logic [`REC_W-1:0]     mem [`REC_DEPTH];
  logic [`REC_IDX_W-1:0] wr_ptr_reg;
  logic [`REC_IDX_W-1:0] newest;
  logic [`REC_IDX_W-1:0] rd_addr;
  logic [`REC_IDX_W:0]   diff;

  always_comb begin
    newest = (wr_ptr_reg == '0) ? `REC_IDX_W'(`REC_DEPTH - 1)
                                : wr_ptr_reg - `REC_ONE;
    diff = {1'b0, newest} - {1'b0, rd_idx};
    rd_addr = diff[`REC_IDX_W] ? diff[`REC_IDX_W-1:0] + `REC_IDX_W'(`REC_DEPTH)
                                 : diff[`REC_IDX_W-1:0];
  end

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_ptr_reg] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (wr_en) begin
      // oldest entry is overwritten once full
      wr_ptr_reg <= (wr_ptr_reg == `REC_IDX_W'(`REC_DEPTH - 1)) ? '0
                    : wr_ptr_reg + `REC_ONE;
      if (count_reg != `REC_IDX_W'(`REC_DEPTH)) begin
        count_reg <= count_reg + `REC_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_reg <= '0;
    end else if (rd_idx < count_reg) begin
      rd_data_reg <= mem[rd_addr];
    end else begin
      rd_data_reg <= '0;
    end
  end
endmodule

//--- dv/meas_front_end.sv
// measurement front end and blocking matrix stand-in
`timescale 1ns/1ps
module meas_front_end (
  input  wire logic             sys_clk,     // clock
  input  wire logic             req,         // start a program cycle
  input  wire logic [9:0][15:0] ph_req,      // phasor parts to present
  input  wire logic             blk_req,     // blocking wanted
  output logic                  cycle_start, // cycle pulse
  output logic      [9:0][15:0] ph,          // phasor parts
  output logic                  block_in     // blocking level
);
  initial begin
    cycle_start = 1'b0;
    ph          = '0;
    block_in    = 1'b0;
  end
  // values only valid at the pulse; scrambled in between
  always @(negedge sys_clk) begin
    cycle_start <= req;
    if (req) begin
      ph       <= ph_req;
      block_in <= blk_req;
    end else begin
      ph       <= ~ph;
      block_in <= ~block_in;
    end
  end
endmodule

//--- dv/test_residual_diff_stage.sv
// self-checking bench of the residual differential stage
`timescale 1ns/1ps
`include "resdiff_params.svh"
module test_residual_diff_stage
  import resdiff_pkg::*;
;
  logic                  sys_clk, resetn, req, blk, cycle_start, block_in;
  logic                  residual_sel, direction_sub, bias_max_mode;
  logic                  cable_end_diff_mode, comp_cmd, energized, cab_ok;
  logic                  force_enable, clr_trip_count, clr_block_count;
  logic                  trip_out, blocked_out, pickup_out;
  logic [1:0]            force_status, condition;
  logic [3:0]            event_mask, event_store;
  logic [9:0][15:0]      ph_req, ph;
  logic [`CUR_W-1:0]     pickup_set, first_turnpoint, second_turnpoint;
  logic [`SLOPE_W-1:0]   first_slope, second_slope;
  logic [`TS_W-1:0]      time_stamp, event_time;
  logic [`GRP_W-1:0]     setting_group;
  logic [`CNT_W-1:0]     trip_count, block_count;
  logic [`REC_W-1:0]     rec_rd_data;
  logic [`REC_IDX_W-1:0] rec_count, rec_rd_idx;
  logic [31:0]           rs;
  logic [52:0]           recq[$];
  int                    n_fail, checks_done, ps, tc, bc, rc, ore, oim, cyc;
  int                    bm, dm, tm;

  meas_front_end i_fe (.sys_clk, .req, .ph_req, .blk_req(blk),
    .cycle_start, .ph, .block_in);

  residual_diff_stage i_dut (
    .sys_clk, .resetn, .cycle_start, .block_in,
    .phase_a_re(ph[0]), .phase_a_im(ph[1]), .phase_b_re(ph[2]),
    .phase_b_im(ph[3]), .phase_c_re(ph[4]), .phase_c_im(ph[5]),
    .res_one_re(ph[6]), .res_one_im(ph[7]), .res_two_re(ph[8]),
    .res_two_im(ph[9]), .residual_sel, .direction_sub, .bias_max_mode,
    .cable_end_diff_mode, .comp_cmd, .energized, .pickup_set,
    .first_turnpoint, .first_slope, .second_turnpoint, .second_slope,
    .force_enable, .force_status, .event_mask, .clr_trip_count,
    .clr_block_count, .time_stamp, .setting_group, .rec_rd_idx,
    .condition, .trip_out, .blocked_out, .pickup_out, .event_store,
    .event_time, .trip_count, .block_count, .rec_rd_data, .rec_count
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // max plus half of min, saturated
  function automatic int mag(int re, int im);
    int a, b, m;
    a = re < 0 ? -re : re;
    b = im < 0 ? -im : im;
    m = a > b ? a + b / 2 : b + a / 2;
    return m > 'hFFFFF ? 'hFFFFF : m;
  endfunction

  task automatic run_cycle(input logic do_comp);
    int p[10];
    int sre, sim, rre, rim, calc, meas, diff, bias, m, ns;
    longint thr, t1, t2;
    logic [31:0] r;
    logic [3:0] ev;
    for (int i = 0; i < 10; i++) begin
      p[i] = int'(xs() % 8192) - 4096;
      ph_req[i] = 16'(p[i]);
    end
    blk = (xs() % 3) == 0;
    @(posedge sys_clk);
    req = 1'b1;
    @(negedge sys_clk);
    r = xs();
    {residual_sel, direction_sub, bias_max_mode} = r[2:0];
    cable_end_diff_mode = r[3] & cab_ok & !do_comp;
    event_mask = r[7:4];
    energized = r[8] | do_comp;
    pickup_set = 20'(100 + r[19:9]);
    first_turnpoint = 20'(r[30:20]);
    r = xs();
    second_turnpoint = first_turnpoint + 20'(r[11:0]);
    first_slope = 16'(1 + r[24:12]);
    second_slope = 16'(1 + r[31:25] * 190);
    setting_group = r[2:0];
    time_stamp = 48'(cyc);
    comp_cmd = do_comp;
    sre = p[0] + p[2] + p[4];
    sim = p[1] + p[3] + p[5];
    if (comp_cmd && energized) begin
      ore = sre;
      oim = sim;
    end
    if (cable_end_diff_mode) begin
      sre -= ore;
      sim -= oim;
    end
    rre = residual_sel ? p[8] : p[6];
    rim = residual_sel ? p[9] : p[7];
    calc = mag(sre, sim);
    meas = mag(rre, rim);
    diff = direction_sub ? mag(sre - rre, sim - rim)
                         : mag(sre + rre, sim + rim);
    bias = bias_max_mode ? meas : (calc + meas) / 2;
    for (int i = 0; i < 3; i++) begin
      m = mag(p[2*i], p[2*i+1]);
      if (bias_max_mode && m > bias) bias = m;
    end
    t1 = first_turnpoint;
    t2 = second_turnpoint;
    thr = pickup_set;
    if (bias > t1) thr += first_slope * ((bias < t2 ? bias : t2) - t1) / 10000;
    if (bias > t2) thr += second_slope * (bias - t2) / 10000;
    if (thr > 'hFFFFF) thr = 'hFFFFF;
    ns = diff <= thr ? 0 : blk ? 2 : 1;
    bm = (ps == 0 || bias > bm) ? bias : bm;
    dm = (ps == 0 || diff > dm) ? diff : dm;
    tm = (ps == 0 || thr > tm) ? int'(thr) : tm;
    ev = {ps == 2 && ns != 2, ns == 2 && ps != 2,
          ps == 1 && ns != 1, ns == 1 && ps != 1};
    tc += ev[0];
    bc += ev[2];
    if (ev[0] | ev[2]) rc = rc < 12 ? rc + 1 : 12;
    @(posedge sys_clk);
    req = 1'b0;
    @(negedge sys_clk);
    comp_cmd = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(pickup_out, ns != 0);
    chk(condition, ns);
    chk(trip_out, ns == 1);
    chk(blocked_out, ns == 2);
    chk(event_store, ev & event_mask);
    chk({trip_count, block_count}, {16'(tc), 16'(bc)});
    chk(rec_count, rc);
    if (ev != 4'h0) chk(event_time, time_stamp);
    ps = ns;
    if (ev[0] | ev[2]) begin
      recq.push_front({time_stamp, ev[2] ? `EV_BLK_ON : `EV_TRIP_ON,
                       setting_group});
      if (recq.size() > `REC_DEPTH) void'(recq.pop_back());
      @(negedge sys_clk);
      chk(rec_rd_data[212:160], recq[0]);
      chk(rec_rd_data[159:100], {20'(bias), 20'(diff), 20'(thr)});
      chk(rec_rd_data[99:40], {20'(bm), 20'(dm), 20'(tm)});
      chk(rec_rd_data[39:0], {20'(calc), 20'(meas)});
    end
  endtask

  initial begin
    rs = 32'h2206;
    rec_rd_idx = 4'h0;
    {resetn, req, blk, cab_ok, residual_sel, direction_sub} = '0;
    {bias_max_mode, cable_end_diff_mode, comp_cmd, energized} = '0;
    {force_enable, force_status, event_mask, clr_trip_count} = '0;
    {clr_block_count, pickup_set, first_turnpoint, second_turnpoint} = '0;
    {first_slope, second_slope, time_stamp, setting_group, ph_req} = '0;
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (60) run_cycle(1'b0);
    cab_ok = 1'b1;
    run_cycle(1'b1);
    repeat (60) run_cycle(1'b0);
    @(negedge sys_clk);
    {clr_trip_count, clr_block_count} = 2'b11;
    @(negedge sys_clk);
    {clr_trip_count, clr_block_count} = 2'b00;
    tc = 0;
    bc = 0;
    chk({trip_count, block_count}, 32'h0);
    repeat (30) run_cycle(1'b0);
    // read back every slot, oldest ones overwritten
    for (int k = 0; k <= `REC_DEPTH; k++) begin
      @(negedge sys_clk);
      rec_rd_idx = 4'(k);
      @(negedge sys_clk);
      chk(rec_rd_data[212:160], k < recq.size() ? recq[k] : 53'h0);
    end
    for (int k = 2; k >= 0; k--) begin
      @(negedge sys_clk);
      force_enable = 1'b1;
      force_status = 2'(k);
      @(negedge sys_clk);
      chk(condition, k);
    end
    report_and_stop();
  end
endmodule
